// ==== verilog/cms_pkg.sv ====
package cms_pkg;

   // ************************************
   // Mode codes
   // ************************************
   localparam logic [2:0] MODE_SSC = 3'h0;
   localparam logic [2:0] MODE_EEN = 3'h1;
   localparam logic [2:0] MODE_STW = 3'h2;
   localparam logic [2:0] MODE_EEW = 3'h3;
   localparam logic [2:0] MODE_NSC = 3'h4;
   localparam logic [2:0] MODE_NEN = 3'h5;
   localparam logic [2:0] MODE_PERI = 3'h6;
   localparam logic [2:0] MODE_NEW = 3'h7;
   localparam int MODE_W = 3;
   localparam int MODE_SPC_BIT = 2;

   // ************************************
   // Register map
   // ************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_MISC = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_LPC = 8'h0c;
   localparam int MISC_FLASH = 0;
   localparam int STAT_SEC = 0;
   localparam int STAT_VRUN = 1;
   localparam int STAT_VPASS = 2;
   localparam int STAT_CLKSRC = 3;
   localparam int STAT_DBG = 4;
   localparam int STAT_PWR = 8;
   localparam int LPC_PSTOP = 0;
   localparam int LPC_RTI = 1;
   localparam int LPC_WDOG = 2;
   localparam logic [2:0] LPC_RESET = 3'h0;

   // ************************************
   // Power states
   // ************************************
   typedef enum logic [3:0] {
      PW_RUN = 4'h1,
      PW_WAIT = 4'h2,
      PW_STOP = 4'h4,
      PW_PSTOP = 4'h8
   } cms_pwr_t;

endpackage

// ==== verilog/cms_config.sv ====
`timescale 1ns/1ns
// Contract
// [R01] Mode pins latched into mode bits at reset release.
// [R02] Flash-visibility pin latched into flash enable at reset release.
// [R03] Flash enable 1 maps internal flash; otherwise flash hidden.
// [R04] Mode bits readable; software may change mode only in limited cases.
// [R05] Code 000 special single chip, debug active at once; else on command.
// [R06] Codes 001 and 011 emulation expanded narrow and wide.
// [R07] Code 010 special test wide, code 100 normal single chip.
// [R08] Codes 101 and 111 normal expanded narrow and wide.
// [R09] Board never straps code 110, peripheral mode.
// [R10] Clock strap high picks Colpitts, low Pierce or external clock.
// [R11] Programmed security holds over every reset and power cycle.
// [R12] Secured normal single chip: all normal except debug blocked.
// [R13] Secured reset into expanded mode: flash disabled, debug blocked.
// [R14] Erase-verify runs in special single chip before unsecure allowed.
// [R15] Reset before reprogramming returns device to secured state.
// [R16] Full stop halts all clocks and oscillator; reset or irq wakes.
// [R17] Pseudo stop keeps oscillator, optional periodic and watchdog units.
// [R18] Wait halts CPU, buses static, peripherals active.
// [R19] In wait each peripheral may gate its own clock.
// [R20] Single-chip modes keep flash enable set regardless of strap.
module cms_config #(
   parameter int NPERIPH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cms_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Strap pins and interrupt pin, asynchronous
   input wire logic modeSelHi,
   input wire logic modeSelMid,
   input wire logic modeSelLo,
   input wire logic flashVisibilityStrap,
   input wire logic clockSourceStrap,
   input wire logic extIrqPin,
   // Flash security and erase-verify
   input wire logic nvSecured,
   input wire logic eraseVerifyDone,
   input wire logic eraseVerifyPass,
   output logic eraseVerifyRun,
   output logic secProgAllow,
   // Debug and CPU events
   input wire logic debugActivateCmd,
   input wire logic stopInstr,
   input wire logic waitInstr,
   input wire logic intIrq,
   input wire logic [NPERIPH-1:0] periphGateReq,
   // Configuration outputs
   output logic [cms_pkg::MODE_W-1:0] modeBits,
   output logic flashVisible,
   output logic debugActive,
   output logic colpittsSel,
   output logic expandedBus,
   output logic wideBus,
   output logic emulationMode,
   output logic modeIllegal,
   // Power control
   output logic oscEnable,
   output logic cpuHalt,
   output logic busHold,
   output logic rtiClkEn,
   output logic wdogClkEn,
   output logic [NPERIPH-1:0] periphClkEn
);
   import cms_pkg::*;

   // ************************************
   // Pin synchronisers
   // ************************************
   // No reset here so the strap levels are settled at release
   logic [5:0] pinMeta;
   logic [5:0] pinSync;
   wire [5:0] pinRaw = {flashVisibilityStrap, extIrqPin, clockSourceStrap,
      modeSelHi, modeSelMid, modeSelLo};
   always_ff @(posedge clk) begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
   end
   wire [2:0] modePins = pinSync[2:0];
   wire extIrq = pinSync[4];
   wire romSync = pinSync[5];

   // ************************************
   // Reset capture
   // ************************************
   logic capDone_ff;
   wire capNow = ~capDone_ff;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         capDone_ff <= 1'b0;
      end else begin
         capDone_ff <= 1'b1;
      end
   end

   // ************************************
   // Register bus decode
   // ************************************
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire hitMode = (paddr == ADDR_MODE);
   wire hitMisc = (paddr == ADDR_MISC);
   wire hitStat = (paddr == ADDR_STAT);
   wire hitLpc = (paddr == ADDR_LPC);
   wire hitAny = hitMode | hitMisc | hitStat | hitLpc;

   // ************************************
   // Mode and flash enable
   // ************************************
   logic [2:0] mode_ff;
   logic [2:0] nxt_mode;
   logic flashEn_ff;
   logic nxt_flashEn;
   logic colp_ff;
   logic secured_ff;

   wire isSpecial = ~mode_ff[MODE_SPC_BIT];
   wire singleChip = (mode_ff == MODE_SSC) | (mode_ff == MODE_NSC);
   wire [2:0] wrMode = pwdata[2:0];
   // Limited switching: only from special modes, never to peripheral
   wire modeWrOk = wr & hitMode & isSpecial & (wrMode != MODE_PERI); // [R04]
   wire flashWrOk = wr & hitMisc & isSpecial;

   assign nxt_mode = capNow ? modePins : // [R01]
      (modeWrOk ? wrMode : mode_ff); // [R04]

   wire [2:0] modeEff = nxt_mode;
   wire scEff = (modeEff == MODE_SSC) | (modeEff == MODE_NSC);
   wire flashReq = capNow ? romSync : // [R02]
      (flashWrOk ? pwdata[MISC_FLASH] : flashEn_ff);
   assign nxt_flashEn = scEff | flashReq; // [R20]

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_ff <= MODE_SSC;
         flashEn_ff <= 1'b1;
         colp_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         flashEn_ff <= nxt_flashEn;
         colp_ff <= capNow ? pinSync[3] : colp_ff; // [R10]
      end
   end

   // Mode decode
   assign emulationMode = (mode_ff == MODE_EEN) |
      (mode_ff == MODE_EEW); // [R06]
   assign wideBus = (mode_ff == MODE_EEW) | (mode_ff == MODE_STW) |
      (mode_ff == MODE_NEW); // [R07] [R08]
   assign expandedBus = ~singleChip & (mode_ff != MODE_PERI); // [R08]
   // Strapped anyway it is flagged, the bus stays off
   assign modeIllegal = (mode_ff == MODE_PERI); // [R09]
   assign modeBits = mode_ff;
   assign colpittsSel = colp_ff;
   // Secured expanded part runs only from external memory
   assign flashVisible = flashEn_ff &
      ~(secured_ff & expandedBus); // [R03] [R13]

   // ************************************
   // Security and erase-verify
   // ************************************
   logic vRun_ff;
   logic vPass_ff;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         secured_ff <= 1'b1; // [R15]
         vRun_ff <= 1'b0;
         vPass_ff <= 1'b0;
      end else begin
         if (capNow) begin
            secured_ff <= nvSecured; // [R11]
         end else if (vPass_ff & ~nvSecured) begin
            secured_ff <= 1'b0; // [R14]
         end
         if (capNow) begin
            vRun_ff <= nvSecured & (modePins == MODE_SSC); // [R14]
         end else if (eraseVerifyDone) begin
            vRun_ff <= 1'b0;
         end
         if (vRun_ff & eraseVerifyDone & eraseVerifyPass) begin
            vPass_ff <= 1'b1; // [R14]
         end
      end
   end
   assign eraseVerifyRun = vRun_ff;
   assign secProgAllow = ~secured_ff | vPass_ff; // [R14]

   // ************************************
   // Debug gating
   // ************************************
   logic dbgCmd_ff;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dbgCmd_ff <= 1'b0;
      end else if (debugActivateCmd) begin
         dbgCmd_ff <= 1'b1; // [R05]
      end
   end
   wire dbgOpen = ~secured_ff | vPass_ff; // [R12] [R13]
   assign debugActive = dbgOpen & capDone_ff &
      ((mode_ff == MODE_SSC) | dbgCmd_ff); // [R05]

   // ************************************
   // Low power control
   // ************************************
   logic [2:0] lpc_ff;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lpc_ff <= LPC_RESET;
      end else if (wr & hitLpc) begin
         lpc_ff <= pwdata[2:0];
      end
   end

   cms_pwr_t pwr_ff;
   cms_pwr_t nxt_pwr;
   wire wakeAny = extIrq | intIrq;
   always_comb begin
      nxt_pwr = pwr_ff;
      case (pwr_ff)
         PW_RUN: begin
            if (stopInstr) begin
               nxt_pwr = lpc_ff[LPC_PSTOP] ? PW_PSTOP : PW_STOP; // [R16]
            end else if (waitInstr) begin
               nxt_pwr = PW_WAIT; // [R18]
            end
         end
         PW_WAIT: begin
            if (wakeAny) begin
               nxt_pwr = PW_RUN;
            end
         end
         PW_STOP: begin
            // Core clock is gone, only the pin can wake it
            if (extIrq) begin
               nxt_pwr = PW_RUN; // [R16]
            end
         end
         PW_PSTOP: begin
            if (wakeAny) begin
               nxt_pwr = PW_RUN; // [R17]
            end
         end
         default: begin
            nxt_pwr = PW_RUN;
         end
      endcase
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pwr_ff <= PW_RUN;
      end else begin
         pwr_ff <= nxt_pwr;
      end
   end

   wire inRun = (pwr_ff == PW_RUN);
   wire inWait = (pwr_ff == PW_WAIT);
   wire inPstop = (pwr_ff == PW_PSTOP);
   assign oscEnable = (pwr_ff != PW_STOP); // [R16]
   assign cpuHalt = ~inRun; // [R18]
   assign busHold = ~inRun; // [R18]
   assign rtiClkEn = inRun | inWait |
      (inPstop & lpc_ff[LPC_RTI]); // [R17]
   assign wdogClkEn = inRun | inWait |
      (inPstop & lpc_ff[LPC_WDOG]); // [R17]
   assign periphClkEn = {NPERIPH{inRun}} |
      ({NPERIPH{inWait}} & ~periphGateReq); // [R18] [R19]

   // ************************************
   // Read data
   // ************************************
   wire [31:0] rdMode = {29'h0, mode_ff};
   wire [31:0] rdMisc = {31'h0, flashEn_ff};
   wire [31:0] rdStat = {20'h0, pwr_ff, 3'h0, debugActive,
      colp_ff, vPass_ff, vRun_ff, secured_ff};
   wire [31:0] rdLpc = {29'h0, lpc_ff};
   // Zero-wait slave; unmapped reads return zero with an error
   assign pready = 1'b1;
   assign pslverr = acc & ~hitAny;
   assign prdata = hitMode ? rdMode :
      hitMisc ? rdMisc :
      hitStat ? rdStat :
      hitLpc ? rdLpc : 32'h0;

   // ************************************
   // Checks
   // ************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_cap;
      $rose(capDone_ff) |-> mode_ff == $past(pinSync[2:0]);
   endproperty
   a_cap: assert property (p_cap) else $error("mode not latched"); // [R01]

   property p_scFlash;
      capDone_ff && (mode_ff == MODE_NSC || mode_ff == MODE_SSC)
         |-> flashEn_ff;
   endproperty
   a_scFlash: assert property (p_scFlash)
      else $error("single chip flash off"); // [R20]

   property p_secExp;
      secured_ff && !vPass_ff && expandedBus |-> !flashVisible && !debugActive;
   endproperty
   a_secExp: assert property (p_secExp)
      else $error("secured expanded leak"); // [R13]

   property p_secDbg;
      secured_ff && !vPass_ff |-> !debugActive;
   endproperty
   a_secDbg: assert property (p_secDbg)
      else $error("secured debug open"); // [R12]

   property p_sscDbg;
      capDone_ff && mode_ff == MODE_SSC && !secured_ff |-> debugActive;
   endproperty
   a_sscDbg: assert property (p_sscDbg)
      else $error("special debug idle"); // [R05]

   sequence s_enterStop;
      inRun && stopInstr && !lpc_ff[LPC_PSTOP];
   endsequence
   property p_stop;
      s_enterStop |=> !oscEnable && periphClkEn == '0 && !rtiClkEn;
   endproperty
   a_stop: assert property (p_stop) else $error("stop clocks run"); // [R16]

   property p_pstop;
      inPstop |-> oscEnable && periphClkEn == '0 &&
         rtiClkEn == lpc_ff[LPC_RTI];
   endproperty
   a_pstop: assert property (p_pstop) else $error("pseudo stop wrong"); // [R17]

   sequence s_enterWait;
      inRun && !stopInstr && waitInstr;
   endsequence
   property p_wait;
      s_enterWait |=> cpuHalt && busHold &&
         periphClkEn == ~periphGateReq;
   endproperty
   a_wait: assert property (p_wait) else $error("wait gating wrong"); // [R19]

   property p_modeLock;
      capDone_ff && !isSpecial |=> mode_ff == $past(mode_ff);
   endproperty
   a_modeLock: assert property (p_modeLock)
      else $error("normal mode changed"); // [R04]

   property p_verify;
      $rose(capDone_ff) |-> vRun_ff == (secured_ff &&
         mode_ff == MODE_SSC);
   endproperty
   a_verify: assert property (p_verify)
      else $error("verify start wrong"); // [R14]

endmodule // cms_config

// ==== test/cms_board_model.sv ====
`timescale 1ns/1ns
// ************************************
// Board straps and debug host
// ************************************
module cms_board_model (
   // Clock
   input wire logic clk,
   // Bench requests
   input wire logic [2:0] strapCode,
   input wire logic flashStrap,
   input wire logic clkStrap,
   input wire logic cmdReq,
   // Pins toward the device
   output logic modeSelHi,
   output logic modeSelMid,
   output logic modeSelLo,
   output logic flashVisibilityStrap,
   output logic clockSourceStrap,
   output logic debugActivateCmd
);
   logic cmdReq_ff;
   logic [2:0] safeCode;
   // Peripheral mode fights the bus, so it is never strapped
   assign safeCode = (strapCode == 3'h6) ? 3'h7 : strapCode;
   assign {modeSelHi, modeSelMid, modeSelLo} = safeCode;
   assign flashVisibilityStrap = flashStrap;
   assign clockSourceStrap = clkStrap;
   // Serial activate command is a one-cycle pulse
   always_ff @(posedge clk) begin
      cmdReq_ff <= cmdReq;
   end
   assign debugActivateCmd = cmdReq & ~cmdReq_ff;
endmodule // cms_board_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
 $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
   import cms_pkg::*;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, gate;
   logic [31:0] pwdata, prdata, rd;
   logic mHi, mMid, mLo, fStrap, cStrap, extIrqPin, nvSecured, evDone;
   logic evPass, evRun, secProgAllow, dbgCmd, stopInstr, waitInstr, intIrq;
   logic [2:0] strapCode, modeBits;
   logic flashStrap, clkStrap, cmdReq, flashVisible, debugActive, colpittsSel;
   logic oscEnable, cpuHalt, busHold, rtiClkEn, wdogClkEn, er, fs, ck;
   logic [3:0] dec;
   logic [2:0] lpcV;
   logic [10:0] pst;
   localparam int S_CMD = 0, S_EV = 1, S_WAIT = 2, S_STOP = 3, S_IRQ = 4;
   logic [7:0] periphGateReq, periphClkEn;
   int n_mismatch, num_checks;
   // ************************************
   // Clock, partner, design
   // ************************************
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   cms_board_model i_cms_board_model (.clk(clk), .strapCode(strapCode),
      .flashStrap(flashStrap), .clkStrap(clkStrap), .cmdReq(cmdReq),
      .modeSelHi(mHi), .modeSelMid(mMid), .modeSelLo(mLo),
      .flashVisibilityStrap(fStrap), .clockSourceStrap(cStrap),
      .debugActivateCmd(dbgCmd));
   cms_config i_cms_config (.clk(clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .modeSelHi(mHi),
      .modeSelMid(mMid), .modeSelLo(mLo), .flashVisibilityStrap(fStrap),
      .clockSourceStrap(cStrap), .extIrqPin(extIrqPin),
      .nvSecured(nvSecured), .eraseVerifyDone(evDone),
      .eraseVerifyPass(evPass), .eraseVerifyRun(evRun),
      .secProgAllow(secProgAllow), .debugActivateCmd(dbgCmd),
      .stopInstr(stopInstr), .waitInstr(waitInstr), .intIrq(intIrq),
      .periphGateReq(periphGateReq), .modeBits(modeBits),
      .flashVisible(flashVisible), .debugActive(debugActive),
      .colpittsSel(colpittsSel), .expandedBus(dec[3]), .wideBus(dec[2]),
      .emulationMode(dec[1]), .modeIllegal(dec[0]), .oscEnable(oscEnable),
      .cpuHalt(cpuHalt), .busHold(busHold), .rtiClkEn(rtiClkEn),
      .wdogClkEn(wdogClkEn), .periphClkEn(periphClkEn));
   // ************************************
   // Expectations and tasks
   // ************************************
   // Single-chip modes keep flash; secured expanded modes hide it
   function automatic logic expFlash(logic [2:0] c, logic s, logic sec);
      if (c == MODE_SSC || c == MODE_NSC) return 1'b1;
      return s & ~sec;
   endfunction
   // Bus shape per code: expanded, wide, emulation, illegal
   function automatic logic [3:0] expDec(logic [2:0] c);
      logic ex, wd, em;
      ex = !(c == MODE_SSC || c == MODE_NSC || c == MODE_PERI);
      wd = (c == MODE_STW || c == MODE_EEW || c == MODE_NEW);
      em = (c == MODE_EEN || c == MODE_EEW);
      return {ex, wd, em, 1'(c == MODE_PERI)};
   endfunction
   task automatic rst(logic [2:0] c, logic f, logic k, logic sec);
      rstn <= 0;
      strapCode <= c;
      flashStrap <= f;
      clkStrap <= k;
      nvSecured <= sec;
      repeat (20) @(posedge clk);
      rstn <= 1;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // Holds the request until pready is sampled high
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // One-cycle pulse on the selected event input
   task automatic step(int k);
      @(posedge clk);
      case (k)
         S_CMD: cmdReq <= 1;
         S_EV: evDone <= 1;
         S_WAIT: waitInstr <= 1;
         S_STOP: stopInstr <= 1;
         default: intIrq <= 1;
      endcase
      @(posedge clk);
      {cmdReq, evDone, waitInstr, stopInstr, intIrq} <= '0;
      #1;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #300000;
      n_mismatch++;
      end_sim;
   end
   // ************************************
   // Scenarios
   // ************************************
   initial begin
      {psel, penable, pwrite, paddr, pwdata, cmdReq, extIrqPin} = '0;
      {evDone, evPass, stopInstr, waitInstr, intIrq, periphGateReq} = '0;
      {strapCode, flashStrap, clkStrap, nvSecured, rstn} = '0;
      void'($urandom(32'h7545));
      for (int c = 0; c < 8; c++) if (c != 6) begin
         fs = 1'($urandom);
         ck = 1'($urandom);
         rst(3'(c), fs, ck, 0);
         `CHK(modeBits, 3'(c))
         `CHK(flashVisible, expFlash(3'(c), fs, 0))
         `CHK(colpittsSel, ck)
         `CHK(debugActive, 1'(c == 0))
         `CHK(dec, expDec(3'(c)))
         `CHK(secProgAllow, 1'b1)
         step(S_CMD);
         @(posedge clk);
         #1 `CHK(debugActive, 1'b1)
         apb(0, ADDR_MODE, 0);
         `CHK({er, rd[2:0]}, {1'b0, 3'(c)})
      end
      apb(0, 8'h10, 0);
      `CHK({er, rd}, {1'b1, 32'h0})
      rst(MODE_EEN, 1, 0, 0);
      apb(1, ADDR_MISC, 32'h0);
      #1 `CHK(flashVisible, 1'b0)
      apb(1, ADDR_MODE, 32'h6);
      #1 `CHK(modeBits, MODE_EEN)
      apb(1, ADDR_MODE, 32'h5);
      apb(1, ADDR_MODE, 32'h1);
      #1 `CHK(modeBits, MODE_NEN)
      rst(MODE_NSC, 1, 0, 1);
      step(S_CMD);
      `CHK({flashVisible, debugActive}, 2'b10)
      rst(MODE_NEN, 1, 0, 1);
      step(S_CMD);
      `CHK({flashVisible, debugActive}, 2'b00)
      rst(MODE_SSC, 0, 0, 1);
      `CHK({evRun, debugActive, secProgAllow}, 3'b100)
      evPass <= 1;
      step(S_EV);
      nvSecured <= 0;
      repeat (2) @(posedge clk);
      apb(0, ADDR_STAT, 0);
      `CHK({rd[STAT_SEC], evRun, debugActive}, 3'b001)
      `CHK(secProgAllow, 1'b1)
      rst(MODE_SSC, 0, 0, 1);
      apb(0, ADDR_STAT, 0);
      `CHK({rd[STAT_SEC], debugActive}, 2'b10)
      rst(MODE_NSC, 0, 0, 0);
      gate = 8'($urandom);
      periphGateReq <= gate;
      step(S_WAIT);
      `CHK({cpuHalt, busHold, periphClkEn}, {2'b11, ~gate})
      step(S_IRQ);
      @(posedge clk);
      #1 `CHK(cpuHalt, 1'b0)
      step(S_STOP);
      `CHK({oscEnable, cpuHalt}, 2'b01)
      step(S_IRQ);
      `CHK(oscEnable, 1'b0)
      extIrqPin <= 1;
      repeat (4) @(posedge clk);
      extIrqPin <= 0;
      #1 `CHK(oscEnable, 1'b1)
      // Random unit enables, stop always routed to pseudo stop
      lpcV = 3'($urandom) | 3'h1;
      pst = {1'b1, lpcV[1], lpcV[2], 8'h0};
      apb(1, ADDR_LPC, {29'h0, lpcV});
      repeat (3) @(posedge clk);
      step(S_STOP);
      `CHK({oscEnable, rtiClkEn, wdogClkEn, periphClkEn}, pst)
      step(S_IRQ);
      @(posedge clk);
      #1 `CHK(cpuHalt, 1'b0)
      end_sim;
   end
endmodule // tb_top
